// [design/slb_consts.svh]
// Constants for the streaming load buffer
`ifndef SLB_CONSTS_SVH
`define SLB_CONSTS_SVH
`define SLB_ADDR_W 32
`define SLB_ITEM_W 128
`define SLB_ITEM_LSB 4
`define SLB_LINE_LSB 6
`define SLB_TAG_W 26
`define SLB_ENTRIES 4
`define SLB_ITEMS 4
`define SLB_IDX_W 2
`define SLB_ITM_W 2
`define SLB_MEM_AW 4
`define SLB_MEM_WORDS 16
`define SLB_CNT_W 4
`define SLB_AGE_W 7
`define SLB_HS_W 2
`define SLB_HS_PRODUCE 2'h0
`define SLB_HS_READY 2'h1
`define SLB_HS_DONE 2'h2
`define SLB_CLK_NS 20
`define SLB_STALE_NS 1280
`define SLB_STALE_CYC ((`SLB_STALE_NS) / (`SLB_CLK_NS))
`endif

// [design/slb_pkg.sv]
// Types for the streaming load buffer
`include "slb_consts.svh"
package slb_pkg;
  typedef enum logic [1:0] {SLB_IDLE, SLB_HIT_RD, SLB_FETCH, SLB_LOCK} slb_state_t;
  typedef struct packed {
    logic valid;
    logic stream;
    logic wc;
    logic [`SLB_ADDR_W-1:0] addr;
  } slb_ld_req_t;
  typedef struct packed {
    logic valid;
    logic hit;
    logic [`SLB_ITEM_W-1:0] data;
  } slb_ld_resp_t;
  typedef struct packed {
    logic valid;
    logic whole_line;
    logic [`SLB_ADDR_W-1:0] addr;
  } slb_mem_req_t;
endpackage : slb_pkg

// [design/slb_line_mem.sv]
// Item storage for all streaming buffer entries
`timescale 1ns/10ps
`default_nettype none
`include "slb_consts.svh"
module slb_line_mem (
  // Clock
  input wire logic clock_i,
  // Write port
  input wire logic we_i,
  input wire logic [`SLB_MEM_AW-1:0] waddr_i,
  input wire logic [`SLB_ITEM_W-1:0] wdata_i,
  // Read port
  input wire logic re_i,
  input wire logic [`SLB_MEM_AW-1:0] raddr_i,
  output logic [`SLB_ITEM_W-1:0] rdata_o
);
  logic [`SLB_ITEM_W-1:0] mem_ff [`SLB_MEM_WORDS];
  logic [`SLB_ITEM_W-1:0] rdata_ff;

  // Data array needs no reset; valid bits guard it
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_ff <= mem_ff[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule : slb_line_mem
`default_nettype wire

// [design/slb_top.sv]
// Streaming load buffer for write-combining memory with locked handshake
// Notes on behaviour
// - A streaming-hinted load to write_combining_memory fetches its whole aligned 64-byte line into a buffer.
// - A later streaming load to another 16-byte item of a buffered line is served without a memory fetch.
// - A buffered line left untouched too long is dropped and refetched on the next access.
// - A line written after buffering is refetched on its next streaming read.
// - Reading the same item of a buffered line twice refetches the line.
// - Buffers are never snooped by other agents, so they give no coherency.
// - Streaming loads may be weakly ordered; the requester fences where order matters.
// - The handshake_variable holds 0 to ask for data, 1 for data ready, 2 for all done.
// - A locked handshake update waits for all pending WC stores to drain before it shows.
// - No younger streaming load passes an older locked operation.
`timescale 1ns/10ps
`default_nettype none
`include "slb_consts.svh"
module slb_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Core load port
  input wire slb_pkg::slb_ld_req_t ld_req_i,
  output logic ld_ready_o,
  output slb_pkg::slb_ld_resp_t ld_resp_o,
  // Local WC stores
  input wire logic st_valid_i,
  input wire logic [`SLB_ADDR_W-1:0] st_addr_i,
  input wire logic st_done_i,
  // Locked handshake exchange
  input wire logic lock_valid_i,
  input wire logic [`SLB_HS_W-1:0] lock_wdata_i,
  output logic lock_done_o,
  output logic [`SLB_HS_W-1:0] lock_rdata_o,
  // Producer side of the handshake_variable
  input wire logic prod_wr_i,
  input wire logic [`SLB_HS_W-1:0] prod_val_i,
  output logic [`SLB_HS_W-1:0] hs_var_o,
  // Memory fetch port
  output slb_pkg::slb_mem_req_t mem_req_o,
  input wire logic mem_beat_valid_i,
  input wire logic [`SLB_ITEM_W-1:0] mem_beat_data_i
);
  // ==========================================================
  // Helpers
  function automatic logic [`SLB_TAG_W-1:0] line_of(input logic [`SLB_ADDR_W-1:0] a);
    line_of = a[`SLB_ADDR_W-1:`SLB_LINE_LSB];
  endfunction : line_of

  function automatic logic [`SLB_ITM_W-1:0] item_of(input logic [`SLB_ADDR_W-1:0] a);
    item_of = a[`SLB_LINE_LSB-1:`SLB_ITEM_LSB];
  endfunction : item_of

  // ==========================================================
  // State
  slb_pkg::slb_state_t state_ff, nxt_state;
  logic valid_ff [`SLB_ENTRIES];
  logic nxt_valid [`SLB_ENTRIES];
  logic [`SLB_TAG_W-1:0] tag_ff [`SLB_ENTRIES];
  logic [`SLB_TAG_W-1:0] nxt_tag [`SLB_ENTRIES];
  logic [`SLB_ITEMS-1:0] mask_ff [`SLB_ENTRIES];
  logic [`SLB_ITEMS-1:0] nxt_mask [`SLB_ENTRIES];
  logic [`SLB_AGE_W-1:0] age_ff [`SLB_ENTRIES];
  logic [`SLB_AGE_W-1:0] nxt_age [`SLB_ENTRIES];
  logic [`SLB_IDX_W-1:0] rr_ff, nxt_rr;
  logic [`SLB_IDX_W-1:0] slot_ff, nxt_slot;
  logic [`SLB_ITM_W-1:0] beat_ff, nxt_beat;
  logic [`SLB_ITM_W-1:0] want_ff, nxt_want;
  logic [`SLB_TAG_W-1:0] fline_ff, nxt_fline;
  logic whole_ff, nxt_whole;
  logic dirty_ff, nxt_dirty;
  logic [`SLB_CNT_W-1:0] wc_cnt_ff, nxt_wc_cnt;
  logic [`SLB_HS_W-1:0] hs_ff, nxt_hs;
  logic [`SLB_HS_W-1:0] lock_val_ff, nxt_lock_val;
  logic ready_ff, nxt_ready;
  slb_pkg::slb_ld_resp_t resp_ff, nxt_resp;
  slb_pkg::slb_mem_req_t mreq_ff, nxt_mreq;
  logic lock_done_ff, nxt_lock_done;
  logic [`SLB_HS_W-1:0] lock_rd_ff, nxt_lock_rd;
  // Memory controls
  logic mem_we, mem_re;
  logic [`SLB_MEM_AW-1:0] mem_waddr, mem_raddr;
  logic [`SLB_ITEM_W-1:0] mem_rdata;
  // Lookup
  logic hit_any, free_any;
  logic [`SLB_IDX_W-1:0] hit_idx, free_idx, victim;
  logic [`SLB_TAG_W-1:0] req_line;
  logic [`SLB_ITM_W-1:0] req_item;

  slb_line_mem u_mem (
    .clock_i(clock_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_beat_data_i),
    .re_i(mem_re),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // ==========================================================
  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_rr = rr_ff;
    nxt_slot = slot_ff;
    nxt_beat = beat_ff;
    nxt_want = want_ff;
    nxt_fline = fline_ff;
    nxt_whole = whole_ff;
    nxt_dirty = dirty_ff;
    nxt_lock_val = lock_val_ff;
    nxt_resp = resp_ff;
    nxt_resp.valid = 1'b0;
    nxt_mreq = mreq_ff;
    nxt_mreq.valid = 1'b0;
    nxt_lock_done = 1'b0;
    nxt_lock_rd = lock_rd_ff;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_waddr = {slot_ff, beat_ff};
    mem_raddr = '0;
    req_line = line_of(ld_req_i.addr);
    req_item = item_of(ld_req_i.addr);
    hit_any = 1'b0;
    hit_idx = '0;
    free_any = 1'b0;
    free_idx = '0;
    victim = '0;
    // Other agents have no way in: nothing here watches foreign writes
    for (int e = 0; e < `SLB_ENTRIES; e++) begin
      nxt_tag[e] = tag_ff[e];
      nxt_mask[e] = mask_ff[e];
      nxt_valid[e] = valid_ff[e];
      nxt_age[e] = age_ff[e] + `SLB_AGE_W'(1);
      if (valid_ff[e] && age_ff[e] == `SLB_AGE_W'(`SLB_STALE_CYC - 1)) begin
        nxt_valid[e] = 1'b0;
      end
      if (st_valid_i && valid_ff[e] && tag_ff[e] == line_of(st_addr_i)) begin
        nxt_valid[e] = 1'b0;
      end
    end
    // Store landing mid-fetch must not leave a stale line behind
    if (st_valid_i && state_ff == slb_pkg::SLB_FETCH && line_of(st_addr_i) == fline_ff) begin
      nxt_dirty = 1'b1;
    end
    nxt_wc_cnt = wc_cnt_ff + `SLB_CNT_W'(st_valid_i) - `SLB_CNT_W'(st_done_i);
    nxt_hs = prod_wr_i ? prod_val_i : hs_ff;
    for (int e = 0; e < `SLB_ENTRIES; e++) begin
      if (nxt_valid[e] && tag_ff[e] == req_line) begin
        hit_any = 1'b1;
        hit_idx = `SLB_IDX_W'(e);
      end
      if (!nxt_valid[e] && !free_any) begin
        free_any = 1'b1;
        free_idx = `SLB_IDX_W'(e);
      end
    end
    case (state_ff)
      slb_pkg::SLB_IDLE: begin
        // Lock taken ahead of a load offered alongside it
        if (lock_valid_i && ready_ff) begin
          nxt_lock_val = lock_wdata_i;
          nxt_state = slb_pkg::SLB_LOCK;
        end else if (ld_req_i.valid && ready_ff) begin
          nxt_want = req_item;
          nxt_fline = req_line;
          nxt_dirty = 1'b0;
          nxt_beat = '0;
          if (ld_req_i.stream && ld_req_i.wc && hit_any && !mask_ff[hit_idx][req_item]) begin
            nxt_mask[hit_idx][req_item] = 1'b1;
            nxt_age[hit_idx] = '0;
            mem_re = 1'b1;
            mem_raddr = {hit_idx, req_item};
            nxt_state = slb_pkg::SLB_HIT_RD;
          end else begin
            // Repeat read reuses its own entry for the refetch
            victim = hit_any ? hit_idx : (free_any ? free_idx : rr_ff);
            nxt_slot = victim;
            nxt_whole = ld_req_i.stream && ld_req_i.wc;
            if (ld_req_i.stream && ld_req_i.wc) begin
              nxt_valid[victim] = 1'b0;
              nxt_rr = (!hit_any && !free_any) ? rr_ff + `SLB_IDX_W'(1) : rr_ff;
            end
            nxt_mreq.valid = 1'b1;
            nxt_mreq.whole_line = ld_req_i.stream && ld_req_i.wc;
            nxt_mreq.addr = (ld_req_i.stream && ld_req_i.wc) ?
              {req_line, `SLB_LINE_LSB'(0)} : {ld_req_i.addr[`SLB_ADDR_W-1:`SLB_ITEM_LSB], `SLB_ITEM_LSB'(0)};
            nxt_state = slb_pkg::SLB_FETCH;
          end
        end
      end
      slb_pkg::SLB_HIT_RD: begin
        nxt_resp.valid = 1'b1;
        nxt_resp.hit = 1'b1;
        nxt_resp.data = mem_rdata;
        nxt_state = slb_pkg::SLB_IDLE;
      end
      slb_pkg::SLB_FETCH: begin
        if (mem_beat_valid_i) begin
          mem_we = whole_ff;
          nxt_beat = beat_ff + `SLB_ITM_W'(1);
          if (!whole_ff || beat_ff == want_ff) begin
            nxt_resp.data = mem_beat_data_i;
          end
          if (!whole_ff || beat_ff == `SLB_ITM_W'(`SLB_ITEMS - 1)) begin
            if (whole_ff && !dirty_ff && !(st_valid_i && line_of(st_addr_i) == fline_ff)) begin
              nxt_valid[slot_ff] = 1'b1;
              nxt_tag[slot_ff] = fline_ff;
              nxt_mask[slot_ff] = `SLB_ITEMS'(1) << want_ff;
              nxt_age[slot_ff] = '0;
            end
            nxt_resp.valid = 1'b1;
            nxt_resp.hit = 1'b0;
            nxt_state = slb_pkg::SLB_IDLE;
          end
        end
      end
      slb_pkg::SLB_LOCK: begin
        // Exchange only shows once older WC stores have drained
        if (wc_cnt_ff == '0) begin
          nxt_lock_done = 1'b1;
          nxt_lock_rd = hs_ff;
          nxt_hs = lock_val_ff;
          nxt_state = slb_pkg::SLB_IDLE;
        end
      end
      default: begin
        nxt_state = slb_pkg::SLB_IDLE;
      end
    endcase
    // One request in flight keeps completion in order, stronger than needed
    nxt_ready = (nxt_state == slb_pkg::SLB_IDLE);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_ff <= slb_pkg::SLB_IDLE;
      for (int e = 0; e < `SLB_ENTRIES; e++) begin
        valid_ff[e] <= 1'b0;
        tag_ff[e] <= '0;
        mask_ff[e] <= '0;
        age_ff[e] <= '0;
      end
      rr_ff <= '0;
      slot_ff <= '0;
      beat_ff <= '0;
      want_ff <= '0;
      fline_ff <= '0;
      whole_ff <= 1'b0;
      dirty_ff <= 1'b0;
      wc_cnt_ff <= '0;
      hs_ff <= `SLB_HS_PRODUCE;
      lock_val_ff <= `SLB_HS_PRODUCE;
      ready_ff <= 1'b0;
      resp_ff <= '0;
      mreq_ff <= '0;
      lock_done_ff <= 1'b0;
      lock_rd_ff <= `SLB_HS_PRODUCE;
    end else begin
      state_ff <= nxt_state;
      for (int e = 0; e < `SLB_ENTRIES; e++) begin
        valid_ff[e] <= nxt_valid[e];
        tag_ff[e] <= nxt_tag[e];
        mask_ff[e] <= nxt_mask[e];
        age_ff[e] <= nxt_age[e];
      end
      rr_ff <= nxt_rr;
      slot_ff <= nxt_slot;
      beat_ff <= nxt_beat;
      want_ff <= nxt_want;
      fline_ff <= nxt_fline;
      whole_ff <= nxt_whole;
      dirty_ff <= nxt_dirty;
      wc_cnt_ff <= nxt_wc_cnt;
      hs_ff <= nxt_hs;
      lock_val_ff <= nxt_lock_val;
      ready_ff <= nxt_ready;
      resp_ff <= nxt_resp;
      mreq_ff <= nxt_mreq;
      lock_done_ff <= nxt_lock_done;
      lock_rd_ff <= nxt_lock_rd;
    end
  end

  assign ld_ready_o = ready_ff;
  assign ld_resp_o = resp_ff;
  assign mem_req_o = mreq_ff;
  assign lock_done_o = lock_done_ff;
  assign lock_rdata_o = lock_rd_ff;
  assign hs_var_o = hs_ff;
endmodule : slb_top
`default_nettype wire

// [verif/slb_top_chk.sv]
// Assertion checker for the streaming load buffer
`timescale 1ns/10ps
`default_nettype none
`include "slb_consts.svh"
module slb_top_chk (
  // Watched ports
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire slb_pkg::slb_ld_req_t ld_req_i,
  input wire logic ld_ready_o,
  input wire slb_pkg::slb_ld_resp_t ld_resp_o,
  input wire logic st_valid_i,
  input wire logic st_done_i,
  input wire logic lock_valid_i,
  input wire logic [`SLB_HS_W-1:0] lock_wdata_i,
  input wire logic lock_done_o,
  input wire logic prod_wr_i,
  input wire logic [`SLB_HS_W-1:0] prod_val_i,
  input wire logic [`SLB_HS_W-1:0] hs_var_o,
  input wire slb_pkg::slb_mem_req_t mem_req_o,
  input wire logic mem_beat_valid_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ========
  // Helpers
  logic tk, lk, sw, busy_ff, nxt_busy;
  logic [`SLB_CNT_W-1:0] pend_ff, nxt_pend;
  logic [`SLB_HS_W-1:0] lkw_ff, nxt_lkw;
  assign tk = ld_ready_o && ld_req_i.valid && !lock_valid_i;
  assign lk = ld_ready_o && lock_valid_i;
  assign sw = ld_req_i.stream && ld_req_i.wc;
  always_comb begin
    nxt_pend = pend_ff + `SLB_CNT_W'(st_valid_i) - `SLB_CNT_W'(st_done_i);
    nxt_busy = lk || (busy_ff && !lock_done_o);
    nxt_lkw = lk ? lock_wdata_i : lkw_ff;
  end
  always_ff @(posedge clock_i) begin
    pend_ff <= reset_n_i ? nxt_pend : '0;
    busy_ff <= reset_n_i && nxt_busy;
    lkw_ff <= reset_n_i ? nxt_lkw : '0;
  end
  // ========
  // Properties
  a_fetch_after_take: assert property (mem_req_o.valid |-> $past(tk))
    else $error("fetch without a load");
  a_fetch_kind: assert property (mem_req_o.valid |-> mem_req_o.whole_line == $past(sw))
    else $error("wrong fetch size");
  a_hit_no_fetch: assert property (tk ##1 !mem_req_o.valid |=> ld_resp_o.valid && ld_resp_o.hit)
    else $error("unfetched load not served");
  a_miss_after_beat: assert property (ld_resp_o.valid && !ld_resp_o.hit |-> $past(mem_beat_valid_i))
    else $error("miss answered before data");
  a_lock_drain: assert property (lock_done_o |-> $past(pend_ff) == '0)
    else $error("lock done with stores pending");
  a_lock_value: assert property (lock_done_o |-> hs_var_o == lkw_ff)
    else $error("lock value not shown");
  a_lock_blocks: assert property (busy_ff && !lock_done_o |-> !ld_ready_o && !ld_resp_o.valid)
    else $error("load passed a lock");
  a_prod_write: assert property ($past(prod_wr_i) && !lock_done_o |-> hs_var_o == $past(prod_val_i))
    else $error("producer write lost");
  c_hit: cover property (ld_resp_o.valid && ld_resp_o.hit);
  c_line: cover property (mem_req_o.valid && mem_req_o.whole_line);
  c_lock: cover property (busy_ff && lock_done_o);
endmodule : slb_top_chk
bind slb_top slb_top_chk slb_top_chk_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .ld_req_i(ld_req_i),
  .ld_ready_o(ld_ready_o), .ld_resp_o(ld_resp_o), .st_valid_i(st_valid_i), .st_done_i(st_done_i),
  .lock_valid_i(lock_valid_i), .lock_wdata_i(lock_wdata_i), .lock_done_o(lock_done_o), .prod_wr_i(prod_wr_i),
  .prod_val_i(prod_val_i), .hs_var_o(hs_var_o), .mem_req_o(mem_req_o), .mem_beat_valid_i(mem_beat_valid_i));
`default_nettype wire

// [verif/slb_mem_model.sv]
// Memory model answering line and item fetches
`timescale 1ns/10ps
`default_nettype none
`include "slb_consts.svh"
module slb_mem_model #(
  parameter int DLY = 3
) (
  // Fetch port
  input wire logic clock_i,
  input wire slb_pkg::slb_mem_req_t req_i,
  output logic beat_valid_o,
  output logic [`SLB_ITEM_W-1:0] beat_data_o
);
  logic [`SLB_ADDR_W-1:0] base;
  initial begin
    beat_valid_o = 1'h0;
    beat_data_o = '0;
    forever begin
      @(posedge clock_i);
      if (req_i.valid) begin
        base = {req_i.addr[`SLB_ADDR_W-1:4], 4'h0};
        repeat (DLY) @(posedge clock_i);
        // Items in address order, one beat each
        for (int i = 0; i < (req_i.whole_line ? 4 : 1); i++) begin
          beat_valid_o <= 1'h1;
          beat_data_o <= {4{base + 32'(i * 16)}};
          @(posedge clock_i);
        end
        // Released data shows junk, never the last beat
        beat_valid_o <= 1'h0;
        beat_data_o <= ~beat_data_o;
      end
    end
  end
endmodule : slb_mem_model
`default_nettype wire

// [verif/streaming_load_buffer_test.sv]
// Self-checking bench for the streaming load buffer
`timescale 1ns/10ps
`default_nettype none
`include "slb_consts.svh"
module streaming_load_buffer_test;
  logic clock_i = 1'h0;
  logic reset_n_i = 1'h0;
  slb_pkg::slb_ld_req_t ld_req_i = '0;
  slb_pkg::slb_ld_resp_t ld_resp_o;
  slb_pkg::slb_mem_req_t mem_req_o;
  logic st_valid_i = 1'h0, st_done_i = 1'h0, lock_valid_i = 1'h0, prod_wr_i = 1'h0;
  logic ld_ready_o, lock_done_o, mem_beat_valid_i;
  logic [`SLB_ADDR_W-1:0] st_addr_i = '0;
  logic [`SLB_HS_W-1:0] lock_wdata_i = '0, prod_val_i = '0, lock_rdata_o, hs_var_o;
  logic [`SLB_ITEM_W-1:0] mem_beat_data_i;
  logic [2:0] flags;
  int mismatches = 0;
  int cmp_count = 0;
  assign flags = {lock_done_o, ld_resp_o.valid, ld_ready_o};
  always #10 clock_i = ~clock_i;
  slb_top slb_top_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .ld_req_i(ld_req_i), .ld_ready_o(ld_ready_o),
    .ld_resp_o(ld_resp_o), .st_valid_i(st_valid_i), .st_addr_i(st_addr_i), .st_done_i(st_done_i),
    .lock_valid_i(lock_valid_i), .lock_wdata_i(lock_wdata_i), .lock_done_o(lock_done_o),
    .lock_rdata_o(lock_rdata_o), .prod_wr_i(prod_wr_i), .prod_val_i(prod_val_i), .hs_var_o(hs_var_o),
    .mem_req_o(mem_req_o), .mem_beat_valid_i(mem_beat_valid_i), .mem_beat_data_i(mem_beat_data_i));
  slb_mem_model #(.DLY(3)) slb_mem_model_i (.clock_i(clock_i), .req_i(mem_req_o),
    .beat_valid_o(mem_beat_valid_i), .beat_data_o(mem_beat_data_i));
  // ========
  // Shared tasks
  task automatic wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [`SLB_ITEM_W-1:0] seen, input logic [`SLB_ITEM_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait at falling edges for ready, answer or lock done
  task automatic wait_on(input int w);
    int n;
    for (n = 0; n < 300; n++) begin
      if (flags[w] === 1'h1) break;
      @(negedge clock_i);
    end
    if (n == 300) begin
      mismatches++;
      wrap_up;
    end
  endtask : wait_on
  task automatic got(input logic [31:0] a, input logic h);
    wait_on(1);
    check(128'(ld_resp_o.hit), 128'(h));
    check(ld_resp_o.data, {4{a[31:4], 4'h0}});
  endtask : got
  task automatic ld(input logic [31:0] a, input logic s, input logic w, input logic h);
    @(negedge clock_i);
    ld_req_i = '{1'h1, s, w, a};
    wait_on(0);
    @(negedge clock_i);
    ld_req_i.valid = 1'h0;
    got(a, h);
  endtask : ld
  task automatic pulse_st(input logic [31:0] a);
    @(negedge clock_i);
    st_valid_i = 1'h1;
    st_addr_i = a;
    @(negedge clock_i);
    st_valid_i = 1'h0;
  endtask : pulse_st
  // ========
  // Scenarios
  task automatic t_line; // Line fill, hits on its other items, repeat-item refetch, then item-only loads
    ld(32'h1000, 1'h1, 1'h1, 1'h0);
    for (int i = 1; i < 4; i++) begin
      ld(32'h1000 + 32'(i * 16), 1'h1, 1'h1, 1'h1);
    end
    ld(32'h1010, 1'h1, 1'h1, 1'h0);
    ld(32'h2000, 1'h1, 1'h0, 1'h0);
    ld(32'h2010, 1'h0, 1'h1, 1'h0);
    $display("Line test done");
  endtask : t_line
  task automatic t_store;
    ld(32'h3000, 1'h1, 1'h1, 1'h0);
    pulse_st(32'h3020);
    st_done_i = 1'h1;
    @(negedge clock_i);
    st_done_i = 1'h0;
    ld(32'h3010, 1'h1, 1'h1, 1'h0);
    $display("Store test done");
  endtask : t_store
  task automatic t_stale;
    ld(32'h4000, 1'h1, 1'h1, 1'h0);
    repeat (30) @(negedge clock_i);
    ld(32'h4010, 1'h1, 1'h1, 1'h1);
    repeat (80) @(negedge clock_i);
    ld(32'h4020, 1'h1, 1'h1, 1'h0);
    $display("Stale test done");
  endtask : t_stale
  // Lock and load offered together, one store still draining
  task automatic t_lock;
    logic sn;
    sn = 1'h0;
    pulse_st(32'h5000);
    lock_valid_i = 1'h1;
    lock_wdata_i = 2'h1;
    ld_req_i = '{1'h1, 1'h1, 1'h1, 32'h6000};
    @(negedge clock_i);
    lock_valid_i = 1'h0;
    repeat (8) begin
      @(negedge clock_i);
      sn = sn | lock_done_o | ld_resp_o.valid;
    end
    check(128'(sn), 128'h0);
    st_done_i = 1'h1;
    @(negedge clock_i);
    st_done_i = 1'h0;
    wait_on(2);
    check(128'({lock_rdata_o, hs_var_o, ld_resp_o.valid}), 128'h2);
    wait_on(0);
    @(negedge clock_i);
    ld_req_i.valid = 1'h0;
    got(32'h6000, 1'h0);
    $display("Lock test done");
  endtask : t_lock
  task automatic t_prod; // Producer publishes its own status
    for (int i = 0; i < 3; i++) begin
      @(negedge clock_i);
      prod_wr_i = 1'h1;
      prod_val_i = 2'((i + 2) % 3);
      @(negedge clock_i);
      prod_wr_i = 1'h0;
      check(128'(hs_var_o), 128'((i + 2) % 3));
    end
    $display("Producer test done");
  endtask : t_prod
  initial begin
    repeat (5) @(negedge clock_i);
    reset_n_i = 1'h1;
    t_line;
    t_store;
    t_stale;
    t_lock;
    t_prod;
    wrap_up;
  end
endmodule : streaming_load_buffer_test
`default_nettype wire
